// *** rtl/fas_defs.svh ***
// Constants of the fault alert supervisor: register offsets, field positions,
// reset values and timing counts. Assumes a 50 MHz system clock.
`ifndef FAS_DEFS_SVH
`define FAS_DEFS_SVH

`define FAS_CLK_MHZ        50
// Qualification times, each in its own unit
`define FAS_T_FILT_NS      2000
`define FAS_T_BRK_STD_US   20
`define FAS_T_BRK_LONG_US  420
`define FAS_T_DEB_MS       100
`define FAS_T_COOL_S       5
`define FAS_T_POR_US       60
`define FAS_ADC_PER_SEC    10
// Derived cycle counts: least times round up
`define FAS_FILT_CYC       ((`FAS_T_FILT_NS * `FAS_CLK_MHZ + 999) / 1000)
`define FAS_BRK_STD_CYC    (`FAS_T_BRK_STD_US * `FAS_CLK_MHZ)
`define FAS_BRK_LONG_CYC   (`FAS_T_BRK_LONG_US * `FAS_CLK_MHZ)
`define FAS_DEB_CYC        (`FAS_T_DEB_MS * `FAS_CLK_MHZ * 1000)
`define FAS_COOL_CYC       (`FAS_T_COOL_S * `FAS_CLK_MHZ * 1000000)
`define FAS_POR_CYC        (`FAS_T_POR_US * `FAS_CLK_MHZ)
`define FAS_ADC_SLOT_CYC   (`FAS_CLK_MHZ * 1000000 / (`FAS_ADC_PER_SEC * 3))
// Sense code for 1.6 mV at 151 uV per step, rounded up
`define FAS_SHORT_CODE     8'h0B

// Register byte offsets
`define FAS_REG_CONTROL    8'h00
`define FAS_REG_ALERT_EN   8'h04
`define FAS_REG_STATUS     8'h08
`define FAS_REG_FAULT      8'h0C
`define FAS_REG_ADC_SENSE  8'h10
`define FAS_REG_ADC_SOURCE 8'h14
`define FAS_REG_ADC_AUX    8'h18

// Control fields
`define FAS_C_OV_RETRY     0
`define FAS_C_UV_RETRY     1
`define FAS_C_OC_RETRY     2
`define FAS_C_SWITCH_ON    3
`define FAS_C_GPO_LEVEL    4
`define FAS_C_CONV_TEST    5
`define FAS_C_PIN_LO       6
`define FAS_C_PIN_HI       7
`define FAS_CONTROL_RST    8'h03
`define FAS_ALERT_EN_RST   6'h00

// Fault and status bit positions
`define FAS_B_OV           0
`define FAS_B_UV           1
`define FAS_B_OC           2
`define FAS_B_PB           3
`define FAS_B_CARD         4
`define FAS_B_SHORT        5
// Insertion clears every flag but the card change flag
`define FAS_INSERT_CLR     6'h2F

`endif

// *** rtl/fas_pkg.sv ***
// Types of the fault alert supervisor.
// Assumes fas_defs.svh carries all numeric constants.
package fas_pkg;

    typedef enum logic {
        FAS_OC_IDLE,
        FAS_OC_COOL
    } fas_oc_state_t;

    typedef enum logic [1:0] {
        FAS_PIN_OPEN_GOOD,
        FAS_PIN_LOW_GOOD,
        FAS_PIN_OUTPUT,
        FAS_PIN_INPUT
    } fas_pin_mode_t;

endpackage : fas_pkg

// *** rtl/fas_top.sv ***
// Fault alert supervisor: qualifies supply faults, drives the pass switch,
// keeps status and sticky faults, raises alert, stores converter results.
// Assumes comparator levels arrive asynchronously; converter and bus logic share clk.
`include "fas_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fas_top #(
    parameter logic [27:0] BRK_CYC      = 28'(`FAS_BRK_STD_CYC),
    parameter logic [27:0] DEB_CYC      = 28'(`FAS_DEB_CYC),
    parameter logic [27:0] COOL_CYC     = 28'(`FAS_COOL_CYC),
    parameter logic [27:0] ADC_SLOT_CYC = 28'(`FAS_ADC_SLOT_CYC)
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [7:0] wb_dat_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic       wb_we_i,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    output logic      [7:0] wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic       supply_ok,
    input  wire logic       breaker_over,
    input  wire logic       upper_supply_limit_input,
    input  wire logic       main_supply_high,
    input  wire logic       lower_supply_limit_input,
    input  wire logic       lower_reset_low,
    input  wire logic       output_feedback,
    input  wire logic       gate_source_ok,
    input  wire logic       card_detect_n,
    input  wire logic       switch_request,
    input  wire logic       timer_low,
    input  wire logic       timer_strapped,
    input  wire logic       gpio_i,
    output logic            gpio_o,
    output logic            gpio_oe,
    output logic            gate_on,
    output logic            alert_n,
    input  wire logic [6:0] dev_addr,
    input  wire logic       ara_req,
    input  wire logic       ara_other_valid,
    input  wire logic [6:0] ara_other_addr,
    input  wire logic       host_addressed,
    output logic            ara_resp,
    output logic      [6:0] ara_addr,
    output logic            adc_start,
    output logic      [1:0] adc_chan,
    input  wire logic       adc_done,
    input  wire logic [7:0] adc_result,
    input  wire logic       aux_analog_input
);
    localparam logic [27:0] FILT_CYC = 28'(`FAS_FILT_CYC);
    localparam logic [27:0] POR_CYC  = 28'(`FAS_POR_CYC);
    localparam int          NSYNC    = 13;

    function automatic logic [27:0] fas_cnt(input logic [27:0] c, input logic run, input logic [27:0] lim);
        if (!run) begin
            return 28'h0000000;
        end
        if (c >= lim) begin
            return c;
        end
        return c + 28'h0000001;
    endfunction : fas_cnt

    // Two-stage synchronisers for the 13 supply, breaker, card, request, timer and gpio pin levels
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= 13'h0100;
        end else begin
            sync1_r <= {gpio_i, timer_strapped, timer_low, switch_request, card_detect_n, gate_source_ok,
                        output_feedback, lower_reset_low, lower_supply_limit_input,
                        main_supply_high, upper_supply_limit_input, breaker_over, supply_ok};
            sync2_r <= sync1_r;
        end
    end
    wire s_sup    = sync2_r[0];
    wire s_brk    = sync2_r[1];
    wire s_ov     = sync2_r[2] | sync2_r[3];
    wire s_uv     = sync2_r[4];
    wire s_uvrst  = sync2_r[5];
    wire s_fb     = sync2_r[6];
    wire s_gs     = sync2_r[7];
    wire s_card_n = sync2_r[8];
    wire s_swreq  = sync2_r[9];
    wire s_tlow   = sync2_r[10];
    wire s_tstrap = sync2_r[11];
    wire s_gpio   = sync2_r[12];

    // State
    logic [27:0] por_cnt_r, ov_f_r, uv_f_r, uvr_f_r, pb_f_r, brk_f_r;
    logic [27:0] ov_clr_r, uv_ok_r, card_deb_r, cool_r, slot_r;
    logic [27:0] por_cnt_nxt, ov_f_nxt, uv_f_nxt, uvr_f_nxt, pb_f_nxt, brk_f_nxt;
    logic [27:0] ov_clr_nxt, uv_ok_nxt, card_deb_nxt, cool_nxt, slot_nxt;
    fas_pkg::fas_oc_state_t oc_st_r, oc_st_nxt;
    logic [7:0]  ctrl_r, ctrl_nxt;
    logic [5:0]  alert_en_r, alert_en_nxt;
    logic [5:0]  now_r, now_nxt;
    logic [5:0]  flags_r, flags_nxt;
    logic [5:0]  pend_r, pend_nxt;
    logic [7:0]  adc_reg_r [3];
    logic [7:0]  adc_reg_nxt [3];
    logic        card_prev_r, card_prev_nxt;
    logic        deb_done_r, deb_done_nxt;
    logic        swreq_prev_r, swreq_prev_nxt;
    logic        gate_nxt, alert_n_nxt, ara_resp_nxt, adc_start_nxt, gpio_oe_nxt;
    logic [1:0]  adc_chan_nxt;
    logic [7:0]  wb_dat_nxt;
    logic        wb_ack_nxt;

    logic        por_act, por_end, wr_hit, ov_q, uv_q, pb_q, brk_q, cool_done, win;
    logic [5:0]  set_v, clr_v;
    logic        hold;
    logic [7:0]  rd;

    always_comb begin
        ctrl_nxt       = ctrl_r;
        alert_en_nxt   = alert_en_r;
        now_nxt        = now_r;
        oc_st_nxt      = oc_st_r;
        adc_reg_nxt    = adc_reg_r;
        card_prev_nxt  = s_card_n;
        swreq_prev_nxt = s_swreq;
        deb_done_nxt   = deb_done_r;
        set_v          = 6'h00;
        clr_v          = 6'h00;
        adc_chan_nxt   = adc_chan;
        // Power-on reset pulse follows the internal supply crossing its lockout level
        por_act     = !s_sup || (por_cnt_r < POR_CYC);
        por_end     = s_sup && (por_cnt_r == POR_CYC - 28'h0000001);
        por_cnt_nxt = fas_cnt(por_cnt_r, s_sup, POR_CYC);
        // Qualification filters restart when their condition lapses
        ov_f_nxt  = fas_cnt(ov_f_r, s_ov, FILT_CYC);
        uv_f_nxt  = fas_cnt(uv_f_r, !s_uv, FILT_CYC);
        uvr_f_nxt = fas_cnt(uvr_f_r, s_uvrst, FILT_CYC);
        pb_f_nxt  = fas_cnt(pb_f_r, !s_fb && gate_on && s_gs, FILT_CYC);
        brk_f_nxt = fas_cnt(brk_f_r, s_brk && gate_on, BRK_CYC);
        ov_q  = ov_f_r >= FILT_CYC;
        uv_q  = uv_f_r >= FILT_CYC;
        pb_q  = pb_f_r >= FILT_CYC;
        brk_q = brk_f_r >= BRK_CYC;
        ov_clr_nxt   = fas_cnt(ov_clr_r, now_r[`FAS_B_OV] && !s_ov, DEB_CYC);
        uv_ok_nxt    = fas_cnt(uv_ok_r, now_r[`FAS_B_UV] && s_uv, DEB_CYC);
        card_deb_nxt = fas_cnt(card_deb_r, !s_card_n && !deb_done_r && !por_act, DEB_CYC);
        cool_nxt     = fas_cnt(cool_r, oc_st_r == fas_pkg::FAS_OC_COOL && s_tstrap, COOL_CYC);
        cool_done    = s_tstrap ? (cool_r >= COOL_CYC) : s_tlow;

        // Overvoltage and undervoltage present bits
        if (ov_q) begin
            now_nxt[`FAS_B_OV] = 1'b1;
        end else if (ov_clr_r >= DEB_CYC) begin
            now_nxt[`FAS_B_OV] = 1'b0;
        end
        if (uv_q) begin
            now_nxt[`FAS_B_UV] = 1'b1;
        end else if (uv_ok_r >= DEB_CYC) begin
            now_nxt[`FAS_B_UV] = 1'b0;
        end
        // Overcurrent trip and cool-down
        unique case (oc_st_r)
            fas_pkg::FAS_OC_IDLE: begin
                if (brk_q) begin
                    now_nxt[`FAS_B_OC] = 1'b1;
                    oc_st_nxt          = fas_pkg::FAS_OC_COOL;
                end
            end
            fas_pkg::FAS_OC_COOL: begin
                if (cool_done) begin
                    now_nxt[`FAS_B_OC] = 1'b0;
                    oc_st_nxt          = fas_pkg::FAS_OC_IDLE;
                end
            end
        endcase
        // Power bad present clears as soon as feedback recovers
        if (s_fb) begin
            now_nxt[`FAS_B_PB] = 1'b0;
        end else if (pb_q) begin
            now_nxt[`FAS_B_PB] = 1'b1;
        end
        // Switch short is judged on each sense result taken with the drive off
        if (adc_done && !ctrl_r[`FAS_C_CONV_TEST] && adc_chan == 2'h0) begin
            now_nxt[`FAS_B_SHORT] = !gate_on && (adc_result >= `FAS_SHORT_CODE);
        end
        // Card detect edges
        if (!por_act && (s_card_n != card_prev_r)) begin
            set_v[`FAS_B_CARD]   = 1'b1;
            now_nxt[`FAS_B_CARD] = !s_card_n;
            deb_done_nxt         = 1'b0;
            if (!s_card_n) begin
                clr_v = `FAS_INSERT_CLR;
            end
        end
        if (card_deb_r >= DEB_CYC) begin
            ctrl_nxt[`FAS_C_SWITCH_ON] = s_swreq;
            deb_done_nxt               = 1'b1;
        end else if (deb_done_r && (s_swreq != swreq_prev_r)) begin
            ctrl_nxt[`FAS_C_SWITCH_ON] = s_swreq;
        end

        // Register writes: one byte lane holds all data
        wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
        if (wr_hit) begin
            unique case (wb_adr_i)
                `FAS_REG_CONTROL:    ctrl_nxt = wb_dat_i;
                `FAS_REG_ALERT_EN:   alert_en_nxt = wb_dat_i[5:0];
                `FAS_REG_FAULT:      clr_v = clr_v | ~wb_dat_i[5:0];
                `FAS_REG_ADC_SENSE:  if (ctrl_r[`FAS_C_CONV_TEST]) adc_reg_nxt[0] = wb_dat_i;
                `FAS_REG_ADC_SOURCE: if (ctrl_r[`FAS_C_CONV_TEST]) adc_reg_nxt[1] = wb_dat_i;
                `FAS_REG_ADC_AUX:    if (ctrl_r[`FAS_C_CONV_TEST]) adc_reg_nxt[2] = wb_dat_i;
                default: ;
            endcase
        end
        if ((ctrl_r[`FAS_C_SWITCH_ON] && !ctrl_nxt[`FAS_C_SWITCH_ON]) || (uvr_f_r >= FILT_CYC)) begin
            clr_v = 6'h3F;
        end
        // Converter sequencing, halted in test mode
        slot_nxt      = fas_cnt(slot_r, !ctrl_r[`FAS_C_CONV_TEST] && !(slot_r >= ADC_SLOT_CYC), ADC_SLOT_CYC);
        adc_start_nxt = !ctrl_r[`FAS_C_CONV_TEST] && (slot_r >= ADC_SLOT_CYC);
        if (adc_done && !ctrl_r[`FAS_C_CONV_TEST]) begin
            adc_reg_nxt[adc_chan] = adc_result;
            adc_chan_nxt          = (adc_chan == 2'h2) ? 2'h0 : adc_chan + 2'h1;
        end
        // Fault flags: set wins over clear, present conditions cannot be cleared
        set_v[`FAS_B_OV]    = ov_q && !now_r[`FAS_B_OV];
        set_v[`FAS_B_UV]    = (uv_q && !now_r[`FAS_B_UV]) || (por_end && !s_uv);
        set_v[`FAS_B_OC]    = brk_q && oc_st_r == fas_pkg::FAS_OC_IDLE;
        set_v[`FAS_B_PB]    = pb_q && !s_fb && !now_r[`FAS_B_PB];
        set_v[`FAS_B_SHORT] = now_nxt[`FAS_B_SHORT] && !now_r[`FAS_B_SHORT];
        if (por_act && !por_end) begin
            flags_nxt = 6'h00;
        end else begin
            flags_nxt = (flags_r & ~(clr_v & ~now_r)) | set_v;
        end
        if (por_act) begin
            ctrl_nxt     = `FAS_CONTROL_RST;
            alert_en_nxt = `FAS_ALERT_EN_RST;
            now_nxt      = 6'h00;
            oc_st_nxt    = fas_pkg::FAS_OC_IDLE;
            deb_done_nxt = 1'b0;
        end
        if (por_end) begin
            now_nxt[`FAS_B_CARD] = !s_card_n;
        end
        // Switch drive
        hold = (ctrl_r[`FAS_C_OV_RETRY] ? now_nxt[`FAS_B_OV] : (now_nxt[`FAS_B_OV] | flags_nxt[`FAS_B_OV]))
            || (ctrl_r[`FAS_C_UV_RETRY] ? now_nxt[`FAS_B_UV] : (now_nxt[`FAS_B_UV] | flags_nxt[`FAS_B_UV]))
            || (ctrl_r[`FAS_C_OC_RETRY] ? now_nxt[`FAS_B_OC] : (now_nxt[`FAS_B_OC] | flags_nxt[`FAS_B_OC]));
        gate_nxt = !por_act && ctrl_nxt[`FAS_C_SWITCH_ON] && now_nxt[`FAS_B_CARD] && !hold && !brk_q;
        // Alert: only newly set, enabled flags arm it
        win          = ara_req && !alert_n && (!ara_other_valid || dev_addr < ara_other_addr);
        ara_resp_nxt = win;
        pend_nxt     = pend_r & flags_nxt & alert_en_nxt;
        if (win || host_addressed) begin
            pend_nxt = 6'h00;
        end
        pend_nxt    = pend_nxt | (flags_nxt & ~flags_r & alert_en_nxt);
        alert_n_nxt = !(|pend_nxt);

        // Pin function
        unique case (fas_pkg::fas_pin_mode_t'({ctrl_r[`FAS_C_PIN_HI], ctrl_r[`FAS_C_PIN_LO]}))
            fas_pkg::FAS_PIN_OPEN_GOOD: gpio_oe_nxt = !s_fb || !gate_on || now_nxt[`FAS_B_PB];
            fas_pkg::FAS_PIN_LOW_GOOD:  gpio_oe_nxt = s_fb && gate_on && !now_nxt[`FAS_B_PB];
            fas_pkg::FAS_PIN_OUTPUT:    gpio_oe_nxt = !ctrl_r[`FAS_C_GPO_LEVEL];
            fas_pkg::FAS_PIN_INPUT:     gpio_oe_nxt = 1'b0;
        endcase

        // Bus read data and acknowledge
        unique case (wb_adr_i)
            `FAS_REG_CONTROL:    rd = ctrl_r;
            `FAS_REG_ALERT_EN:   rd = {2'h0, alert_en_r};
            `FAS_REG_STATUS:     rd = {gate_on, s_gpio, now_r};
            `FAS_REG_FAULT:      rd = {2'h0, flags_r};
            `FAS_REG_ADC_SENSE:  rd = adc_reg_r[0];
            `FAS_REG_ADC_SOURCE: rd = adc_reg_r[1];
            `FAS_REG_ADC_AUX:    rd = adc_reg_r[2];
            default:             rd = 8'h00;
        endcase
        wb_ack_nxt = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wb_dat_nxt = (wb_ack_nxt && !wb_we_i) ? rd : 8'h00;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_r    <= '0;
            ov_f_r       <= '0;
            uv_f_r       <= '0;
            uvr_f_r      <= '0;
            pb_f_r       <= '0;
            brk_f_r      <= '0;
            ov_clr_r     <= '0;
            uv_ok_r      <= '0;
            card_deb_r   <= '0;
            cool_r       <= '0;
            slot_r       <= '0;
            oc_st_r      <= fas_pkg::FAS_OC_IDLE;
            ctrl_r       <= `FAS_CONTROL_RST;
            alert_en_r   <= `FAS_ALERT_EN_RST;
            now_r        <= '0;
            flags_r      <= '0;
            pend_r       <= '0;
            adc_reg_r    <= '{default: 8'h00};
            card_prev_r  <= 1'b1;
            swreq_prev_r <= 1'b0;
            deb_done_r   <= 1'b0;
            gate_on      <= 1'b0;
            alert_n      <= 1'b1;
            ara_resp     <= 1'b0;
            ara_addr     <= 7'h00;
            adc_start    <= 1'b0;
            adc_chan     <= 2'h0;
            gpio_oe      <= 1'b0;
            gpio_o       <= 1'b0;
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 8'h00;
        end else begin
            por_cnt_r    <= por_cnt_nxt;
            ov_f_r       <= ov_f_nxt;
            uv_f_r       <= uv_f_nxt;
            uvr_f_r      <= uvr_f_nxt;
            pb_f_r       <= pb_f_nxt;
            brk_f_r      <= brk_f_nxt;
            ov_clr_r     <= ov_clr_nxt;
            uv_ok_r      <= uv_ok_nxt;
            card_deb_r   <= card_deb_nxt;
            cool_r       <= cool_nxt;
            slot_r       <= slot_nxt;
            oc_st_r      <= oc_st_nxt;
            ctrl_r       <= ctrl_nxt;
            alert_en_r   <= alert_en_nxt;
            now_r        <= now_nxt;
            flags_r      <= flags_nxt;
            pend_r       <= pend_nxt;
            adc_reg_r    <= adc_reg_nxt;
            card_prev_r  <= card_prev_nxt;
            swreq_prev_r <= swreq_prev_nxt;
            deb_done_r   <= deb_done_nxt;
            gate_on      <= gate_nxt;
            alert_n      <= alert_n_nxt;
            ara_resp     <= ara_resp_nxt;
            ara_addr     <= ara_resp_nxt ? dev_addr : 7'h00;
            adc_start    <= adc_start_nxt;
            adc_chan     <= adc_chan_nxt;
            gpio_oe      <= gpio_oe_nxt;
            gpio_o       <= 1'b0;
            wb_ack_o     <= wb_ack_nxt;
            wb_dat_o     <= wb_dat_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ov_gate_off: assert property (now_r[`FAS_B_OV] |-> !gate_on) else $error("gate on during overvoltage");
    a_uv_gate_off: assert property (now_r[`FAS_B_UV] |-> !gate_on) else $error("gate on during undervoltage");
    a_oc_gate_off: assert property (now_r[`FAS_B_OC] |-> !gate_on) else $error("gate on during overcurrent");
    a_card_removal: assert property ((s_card_n && !card_prev_r && !por_act) |=> (!now_r[`FAS_B_CARD] && !gate_on && flags_r[`FAS_B_CARD])) else $error("card removal not handled");
    a_alert_masked: assert property (!alert_n |-> |(flags_r & alert_en_r)) else $error("alert without enabled flag");
    a_flag_kept: assert property ((flags_r[`FAS_B_OV] && now_r[`FAS_B_OV] && !por_act) |=> flags_r[`FAS_B_OV]) else $error("present flag cleared");
    a_por_clears: assert property ((por_act && !por_end) |=> (flags_r == 6'h00 && ctrl_r == `FAS_CONTROL_RST)) else $error("reset pulse left state");
    a_test_halts: assert property (ctrl_r[`FAS_C_CONV_TEST] |=> !adc_start) else $error("conversion in test mode");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    a_ara_release: assert property (ara_resp |-> (alert_n && ara_addr == $past(dev_addr))) else $error("response without release");

endmodule : fas_top

`default_nettype wire

// *** tb/fas_adc_model.sv ***
// Converter stand-in for fas_top: answers each start with one result byte.
// Assumes starts are spaced wider than the slow answer of six cycles.
`timescale 1ns/1ps
`default_nettype none
module fas_adc_model (
    input  wire logic       clk,
    input  wire logic       adc_start,
    input  wire logic [1:0] adc_chan,
    output logic            adc_done,
    output logic      [7:0] adc_result
);
    logic slow;
    initial begin
        {adc_done, adc_result, slow} = 10'h000;
        forever begin
            @(posedge clk);
            if (adc_start === 1'h1) begin
                repeat (slow ? 6 : 1) @(posedge clk);
                adc_result <= 8'h05 + {1'h0, adc_chan, 5'h00};
                adc_done <= 1'h1;
                @(posedge clk);
                adc_done <= 1'h0;
                // Result is stale once done drops, so show its inverse
                adc_result <= ~adc_result;
                slow = ~slow;
            end
        end
    end
endmodule : fas_adc_model
`default_nettype wire

// *** tb/tb.sv ***
// Bench for fas_top: bus, overvoltage, alert response and converter checks.
// Assumes fas_adc_model answers the converter port.
`timescale 1ns/1ps
`default_nettype none
`include "fas_defs.svh"
module tb;
    logic        clk, rst_n, cyc, stb, we, ovi, ara, ack, gate, alrt, resp, done, start, oe;
    logic [3:0]  sel, nsel;
    logic [7:0]  adr, wd, rd, dat_o, res;
    logic [6:0]  aadr, da, oa;
    logic [1:0]  ch;
    logic [13:0] lv;
    logic [31:0] lf;
    int          n_errors, check_count;
    always #10 clk = ~clk;
    fas_top #(.DEB_CYC(28'hC8), .COOL_CYC(28'h12C), .ADC_SLOT_CYC(28'h32)) fas_top_i (
        .clk(clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .supply_ok(lv[0]),
        .breaker_over(lv[1]), .upper_supply_limit_input(ovi), .main_supply_high(lv[2]),
        .lower_supply_limit_input(lv[3]), .lower_reset_low(lv[4]), .output_feedback(lv[5]),
        .gate_source_ok(lv[6]), .card_detect_n(lv[7]), .switch_request(lv[8]), .timer_low(lv[9]),
        .timer_strapped(lv[10]), .gpio_i(lv[11]), .gpio_o(), .gpio_oe(oe), .gate_on(gate),
        .alert_n(alrt), .dev_addr(da), .ara_req(ara), .ara_other_valid(lv[12]),
        .ara_other_addr(oa), .host_addressed(lv[13]), .ara_resp(resp), .ara_addr(aadr),
        .adc_start(start), .adc_chan(ch), .adc_done(done), .adc_result(res), .aux_analog_input(lv[1]));
    fas_adc_model fas_adc_model_i (.clk(clk), .adc_start(start), .adc_chan(ch), .adc_done(done),
        .adc_result(res));
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        int k;
        @(posedge clk);
        {cyc, stb, we, adr, wd, sel} <= {2'h3, w, a, d, nsel};
        k = 0;
        do begin @(posedge clk); k++; end while (ack !== 1'h1 && k < 50);
        rd = dat_o;
        {cyc, stb, we} <= 3'h0;
        if (k >= 50) begin
            n_errors++;
            complete_run();
        end
    endtask : bus
    initial begin
        {clk, rst_n, cyc, stb, we, ovi, ara, adr, wd} = '0;
        {sel, nsel, da, oa} = {4'hF, 4'hF, 7'h13, 7'h7F};
        {n_errors, check_count, lf, lv} = {32'h0, 32'h0, 32'h536B, 14'h1169};
        repeat (6) @(posedge clk);
        chk({6'h0, alrt, gate}, 8'h02, "reset outputs");
        rst_n <= 1'h1;
        // Reset pulse plus insertion debounce must be over before switch-on is latched
        repeat (3300) @(posedge clk);
        bus(`FAS_REG_CONTROL, 1'h0, 8'h00); chk(rd, `FAS_CONTROL_RST | 8'h08, "control");
        chk({7'h0, gate}, 8'h01, "gate on");
        bus(`FAS_REG_ALERT_EN, 1'h0, 8'h00); chk(rd, 8'h00, "alert enables");
        bus(8'h20, 1'h0, 8'h00); chk(rd, 8'h00, "unmapped read");
        bus(`FAS_REG_ADC_SENSE, 1'h0, 8'h00); chk(rd, 8'h05, "sense result");
        bus(`FAS_REG_ADC_SOURCE, 1'h0, 8'h00); chk(rd, 8'h25, "source result");
        bus(`FAS_REG_ADC_AUX, 1'h0, 8'h00);
        chk(rd, 8'h45, "aux result");
        $display("Test start done");
        bus(`FAS_REG_ALERT_EN, 1'h1, 8'h01);
        nsel = 4'hE;
        bus(`FAS_REG_ALERT_EN, 1'h1, 8'h3F);
        nsel = 4'hF;
        bus(`FAS_REG_ALERT_EN, 1'h0, 8'h00);
        chk(rd, 8'h01, "masked write ignored");
        @(posedge clk) ovi <= 1'h1;
        repeat (150) @(posedge clk);
        bus(`FAS_REG_STATUS, 1'h0, 8'h00); chk(rd & 8'h81, 8'h01, "ov status");
        bus(`FAS_REG_FAULT, 1'h0, 8'h00); chk(rd & 8'h01, 8'h01, "ov flag");
        chk({7'h0, alrt}, 8'h00, "alert low");
        chk({7'h0, oe}, 8'h01, "pin low while off");
        @(posedge clk) ara <= 1'h1;
        @(posedge clk) ara <= 1'h0;
        #1 chk({resp, aadr}, 8'h93, "alert response");
        @(posedge clk) #1 chk({6'h0, resp, alrt}, 8'h01, "alert released");
        bus(`FAS_REG_FAULT, 1'h1, 8'h00);
        bus(`FAS_REG_FAULT, 1'h0, 8'h00); chk(rd & 8'h01, 8'h01, "present flag kept");
        chk({7'h0, alrt}, 8'h01, "no re-alert");
        @(posedge clk) ovi <= 1'h0;
        // Present bit needs the full debounce before the flag can be cleared
        repeat (250) @(posedge clk);
        chk({7'h0, gate}, 8'h01, "retry on");
        chk({7'h0, oe}, 8'h00, "pin released when good");
        bus(`FAS_REG_FAULT, 1'h0, 8'h00);
        chk(rd & 8'h01, 8'h01, "retry keeps flag");
        bus(`FAS_REG_FAULT, 1'h1, 8'h00);
        bus(`FAS_REG_FAULT, 1'h0, 8'h00);
        chk(rd & 8'h01, 8'h00, "flag cleared");
        $display("Test overvoltage done");
        bus(`FAS_REG_CONTROL, 1'h1, 8'h2B);
        repeat (2) begin
            lf = nx(lf);
            bus(`FAS_REG_ADC_AUX, 1'h1, lf[7:0]);
            bus(`FAS_REG_ADC_AUX, 1'h0, 8'h00); chk(rd, lf[7:0], "test mode result");
        end
        $display("Test converter done");
        @(posedge clk) lv[7] <= 1'h1;
        repeat (5) @(posedge clk);
        chk({7'h0, gate}, 8'h00, "card removed");
        bus(`FAS_REG_FAULT, 1'h0, 8'h00);
        chk(rd & 8'h10, 8'h10, "card change flag");
        $display("Test card done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
